// ===== src/bdmi_regs.vh
// Purpose: constants for the banked data memory with indirect access
// Assumes: 8-bit locations, 256 locations per bank
// Notes:   definitions only
`ifndef BDMI_REGS_VH
`define BDMI_REGS_VH

// special function register offsets
`define BDMI_OFS_PORT_FIRST   8'h00
`define BDMI_OFS_PTR_FIRST    8'h01
`define BDMI_OFS_PORT_SECOND  8'h02
`define BDMI_OFS_PTR_SECOND   8'h03
`define BDMI_OFS_BANK_SELECT  8'h04
`define BDMI_OFS_NVM_CTRL     8'h40

// general purpose / display area starts here, special area below
`define BDMI_GP_BASE          8'h80

// bank select field position and codes
`define BDMI_BANK_MSB         1
`define BDMI_BANK_LSB         0
`define BDMI_BANK0            2'h0
`define BDMI_BANK1            2'h1
`define BDMI_BANK2            2'h2
`define BDMI_BANK_UNDEF       2'h3

// reset values
`define BDMI_RST_PTR          8'h00
`define BDMI_RST_BANK         2'h0
`define BDMI_RST_NVM_CTRL     8'h00
`define BDMI_ZERO_BYTE        8'h00

`endif

// ===== src/bdmi_core.v
// Purpose: banked 8-bit data memory with two pointer/indirect-port pairs
// Assumes: core drives one read or one write strobe per cycle, synchronous
// Notes:   read data stand in the cycle after the read strobe only
//
// Overview of operation
// RULE1: every location holds one byte; each access moves eight bits.
// RULE2: memory splits into special registers, general purpose storage, display memory.
// RULE3: each write into display memory is forwarded at once to the display; a write while sys_reset is high updates display memory but is not forwarded.
// RULE4: display memory shares general purpose addresses; only the bank tells them apart.
// RULE5: special registers decode alike in all banks, except 40H only in bank 1.
// RULE6: the address space of every bank starts at 00H.
// RULE7: an indirect port access goes to the location its paired pointer holds.
// RULE8: first pointer reaches bank 0 only; second pointer uses the bank select.
// RULE9: a pointer aimed at an indirect port reads 00H and drops writes.
// RULE10: both pointers are real storage, readable and writable like data.
// RULE11: direct accesses always go to bank 0, whatever the bank select holds.
// RULE12: unused special register locations read as zero.
// RULE13: protected special register bits cannot be altered by program writes.
// RULE14: every general purpose location is readable and writable.
// RULE15: bank field codes 00, 01, 10 pick banks 0, 1, 2; 11 undefined.
// RULE16: any reset clears the bank, except watchdog timeout in power down.
// RULE17: second pointer with undefined bank code reads zero, drops writes.
// RULE18: the full eight-bit pointer value is the location address.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "bdmi_regs.vh"

module bdmi_core (
    clock,
    rst_n,
    addr,
    wdata,
    wr_strobe,
    rd_strobe,
    rdata,
    sys_reset,
    reset_keep_bank,
    bank_select_out,
    ptr_first_out,
    ptr_second_out,
    nvm_ctrl_out,
    disp_wr_valid,
    disp_wr_addr,
    disp_wr_data
);
    input         clock;
    input         rst_n;
    input  [7:0]  addr;
    input  [7:0]  wdata;
    input         wr_strobe;
    input         rd_strobe;
    output [7:0]  rdata;
    input         sys_reset;
    input         reset_keep_bank;
    output [1:0]  bank_select_out;
    output [7:0]  ptr_first_out;
    output [7:0]  ptr_second_out;
    output [7:0]  nvm_ctrl_out;
    output        disp_wr_valid;
    output [6:0]  disp_wr_addr;
    output [7:0]  disp_wr_data;

    // target classes of a resolved access
    localparam [2:0] TGT_ZERO   = 3'h0;
    localparam [2:0] TGT_PTR1   = 3'h1;
    localparam [2:0] TGT_PTR2   = 3'h2;
    localparam [2:0] TGT_BANKSEL = 3'h3;
    localparam [2:0] TGT_NVM    = 3'h4;
    localparam [2:0] TGT_GP0    = 3'h5;
    localparam [2:0] TGT_GP2    = 3'h6;
    localparam [2:0] TGT_DISP   = 3'h7;

    reg  [7:0]  ptr_first_reg;
    reg  [7:0]  ptr_second_reg;
    reg  [1:0]  bank_select_reg;
    reg  [7:0]  nvm_ctrl_reg;
    reg  [7:0]  rdata_reg;
    reg         disp_wr_valid_reg;
    reg  [6:0]  disp_wr_addr_reg;
    reg  [7:0]  disp_wr_data_reg;

    reg  [7:0]  gp0_mem  [0:127];
    reg  [7:0]  gp2_mem  [0:127];
    reg  [7:0]  disp_mem [0:127];

    reg  [1:0]  eff_bank;
    reg  [7:0]  eff_addr;
    reg         eff_void;
    reg  [2:0]  target;
    reg  [7:0]  rdata_next;
    reg  [1:0]  bank_select_next;

    // map a bank and an in-bank address onto a storage target
    function [2:0] bdmi_decode;
        input [1:0] bank;
        input [7:0] loc;
        begin
            if (loc >= `BDMI_GP_BASE) begin
                // RULE4: bank picks area
                if (bank == `BDMI_BANK1) begin
                    bdmi_decode = TGT_DISP;
                end else if (bank == `BDMI_BANK2) begin
                    bdmi_decode = TGT_GP2;
                end else if (bank == `BDMI_BANK0) begin
                    bdmi_decode = TGT_GP0;
                end else begin
                    bdmi_decode = TGT_ZERO;
                end
            // RULE5: bank 1 only
            end else if (loc == `BDMI_OFS_NVM_CTRL) begin
                if (bank == `BDMI_BANK1) begin
                    bdmi_decode = TGT_NVM;
                end else begin
                    bdmi_decode = TGT_ZERO;
                end
            end else if (loc == `BDMI_OFS_PTR_FIRST) begin
                bdmi_decode = TGT_PTR1;
            end else if (loc == `BDMI_OFS_PTR_SECOND) begin
                bdmi_decode = TGT_PTR2;
            end else if (loc == `BDMI_OFS_BANK_SELECT) begin
                bdmi_decode = TGT_BANKSEL;
            end else begin
                // RULE12: unused reads zero
                bdmi_decode = TGT_ZERO;
            end
        end
    endfunction

    // resolve direct or indirect address
    always @* begin
        eff_void = 1'b0;
        if (addr == `BDMI_OFS_PORT_FIRST) begin
            // RULE7: follow pointer
            // RULE8: first pair bank 0
            // RULE18: full pointer value
            eff_bank = `BDMI_BANK0;
            eff_addr = ptr_first_reg;
        end else if (addr == `BDMI_OFS_PORT_SECOND) begin
            // RULE8: second pair banked
            eff_bank = bank_select_reg;
            eff_addr = ptr_second_reg;
            // RULE17: undefined bank void
            if (bank_select_reg == `BDMI_BANK_UNDEF) begin
                eff_void = 1'b1;
            end
        end else begin
            // RULE11: direct is bank 0
            // RULE6: space starts at 00H
            eff_bank = `BDMI_BANK0;
            eff_addr = addr;
        end
        // RULE9: pointer at a port
        if ((addr == `BDMI_OFS_PORT_FIRST || addr == `BDMI_OFS_PORT_SECOND) &&
            (eff_addr == `BDMI_OFS_PORT_FIRST || eff_addr == `BDMI_OFS_PORT_SECOND)) begin
            eff_void = 1'b1;
        end
        if (eff_void) begin
            target = TGT_ZERO;
        end else begin
            target = bdmi_decode(eff_bank, eff_addr);
        end
    end

    // read mux; the upper bank bits read as zero
    always @* begin
        rdata_next = `BDMI_ZERO_BYTE;
        if (rd_strobe) begin
            case (target)
                TGT_PTR1: begin
                    rdata_next = ptr_first_reg;
                end
                TGT_PTR2: begin
                    rdata_next = ptr_second_reg;
                end
                TGT_BANKSEL: begin
                    rdata_next = {6'h00, bank_select_reg};
                end
                TGT_NVM: begin
                    rdata_next = nvm_ctrl_reg;
                end
                TGT_GP0: begin
                    rdata_next = gp0_mem[eff_addr[6:0]];
                end
                TGT_GP2: begin
                    rdata_next = gp2_mem[eff_addr[6:0]];
                end
                TGT_DISP: begin
                    rdata_next = disp_mem[eff_addr[6:0]];
                end
                default: begin
                    rdata_next = `BDMI_ZERO_BYTE;
                end
            endcase
        end
    end

    // bank select next value, including the reset cause rule
    always @* begin
        bank_select_next = bank_select_reg;
        if (wr_strobe && target == TGT_BANKSEL) begin
            // RULE13: bits 7..2 protected
            // RULE15: two-bit field
            bank_select_next = wdata[`BDMI_BANK_MSB:`BDMI_BANK_LSB];
        end
        // RULE16: watchdog wake keeps bank
        if (sys_reset && !reset_keep_bank) begin
            bank_select_next = `BDMI_RST_BANK;
        end
    end

    // control registers; a write in the same cycle as a device reset loses,
    // except a bank select write while reset_keep_bank is high, which still lands
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr_first_reg     <= `BDMI_RST_PTR;
            ptr_second_reg    <= `BDMI_RST_PTR;
            bank_select_reg   <= `BDMI_RST_BANK;
            nvm_ctrl_reg      <= `BDMI_RST_NVM_CTRL;
            rdata_reg         <= `BDMI_ZERO_BYTE;
            disp_wr_valid_reg <= 1'b0;
            disp_wr_addr_reg  <= 7'h00;
            disp_wr_data_reg  <= `BDMI_ZERO_BYTE;
        end else begin
            // RULE1: byte-wide read data
            rdata_reg         <= rdata_next;
            bank_select_reg   <= bank_select_next;
            disp_wr_valid_reg <= 1'b0;
            if (sys_reset) begin
                ptr_first_reg  <= `BDMI_RST_PTR;
                ptr_second_reg <= `BDMI_RST_PTR;
                nvm_ctrl_reg   <= `BDMI_RST_NVM_CTRL;
            end else if (wr_strobe) begin
                // RULE10: pointers are storage
                if (target == TGT_PTR1) begin
                    ptr_first_reg <= wdata;
                end
                if (target == TGT_PTR2) begin
                    ptr_second_reg <= wdata;
                end
                if (target == TGT_NVM) begin
                    nvm_ctrl_reg <= wdata;
                end
                // RULE3: forward display write
                if (target == TGT_DISP) begin
                    disp_wr_valid_reg <= 1'b1;
                    disp_wr_addr_reg  <= eff_addr[6:0];
                    disp_wr_data_reg  <= wdata;
                end
            end
        end
    end

    // data arrays are volatile and carry no reset
    always @(posedge clock) begin
        if (wr_strobe) begin
            // RULE14: general purpose write
            // RULE2: three areas
            if (target == TGT_GP0) begin
                gp0_mem[eff_addr[6:0]] <= wdata;
            end
            if (target == TGT_GP2) begin
                gp2_mem[eff_addr[6:0]] <= wdata;
            end
            if (target == TGT_DISP) begin
                disp_mem[eff_addr[6:0]] <= wdata;
            end
        end
    end

    assign rdata           = rdata_reg;
    assign bank_select_out = bank_select_reg;
    assign ptr_first_out   = ptr_first_reg;
    assign ptr_second_out  = ptr_second_reg;
    assign nvm_ctrl_out    = nvm_ctrl_reg;
    assign disp_wr_valid   = disp_wr_valid_reg;
    assign disp_wr_addr    = disp_wr_addr_reg;
    assign disp_wr_data    = disp_wr_data_reg;

endmodule

// ===== tb/bdmi_core_chk.sv
// Purpose: port-level checks of the banked data memory
// Assumes: single clock, async active-low reset
// Notes:   bound to every bdmi_core instance
`timescale 1ns/1ns
module bdmi_chk (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_strobe,
    input wire logic       rd_strobe,
    input wire logic [7:0] rdata,
    input wire logic       sys_reset,
    input wire logic       reset_keep_bank,
    input wire logic [1:0] bank_select_out,
    input wire logic [7:0] ptr_first_out,
    input wire logic [7:0] ptr_second_out,
    input wire logic [7:0] nvm_ctrl_out,
    input wire logic       disp_wr_valid,
    input wire logic [6:0] disp_wr_addr,
    input wire logic [7:0] disp_wr_data
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE: assert property (!rd_strobe |=> rdata == 8'h00)
        else $error("rdata not zero without read");
    AST_BANK_WR: assert property (wr_strobe && addr == 8'h04 && !sys_reset
        |=> bank_select_out == $past(wdata[1:0])) else $error("bank write lost");
    AST_PTR1_WR: assert property (wr_strobe && addr == 8'h01 && !sys_reset
        |=> ptr_first_out == $past(wdata)) else $error("first pointer write lost");
    AST_PTR2_WR: assert property (wr_strobe && addr == 8'h03 && !sys_reset
        |=> ptr_second_out == $past(wdata)) else $error("second pointer write lost");
    // a bank select write, direct or through a port, may legally move the bank during a kept reset
    AST_KEEP: assert property (sys_reset && reset_keep_bank && !wr_strobe
        |=> $stable(bank_select_out)) else $error("bank changed on kept reset");
    AST_CLR: assert property (sys_reset && !reset_keep_bank
        |=> bank_select_out == 2'h0 && ptr_first_out == 8'h00 && ptr_second_out == 8'h00)
        else $error("reset no clear");
    AST_DISP: assert property (wr_strobe && addr == 8'h02 && bank_select_out == 2'h1
        && ptr_second_out[7] && !sys_reset |=> disp_wr_valid && disp_wr_data == $past(wdata)
        && disp_wr_addr == $past(ptr_second_out[6:0])) else $error("display write lost");
    AST_DIRECT: assert property (wr_strobe && addr != 8'h02 |=> !disp_wr_valid)
        else $error("direct write reached display");
    AST_NVM: assert property (wr_strobe && addr == 8'h02 && ptr_second_out == 8'h40
        && bank_select_out == 2'h1 && !sys_reset |=> nvm_ctrl_out == $past(wdata))
        else $error("nvm control write lost");
    AST_SELF: assert property (rd_strobe && addr == 8'h00 && ptr_first_out[7:2] == 6'h00
        && !ptr_first_out[0] |=> rdata == 8'h00) else $error("port self read not zero");
endmodule

bind bdmi_core bdmi_chk i_chk (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .sys_reset(sys_reset),
    .reset_keep_bank(reset_keep_bank), .bank_select_out(bank_select_out),
    .ptr_first_out(ptr_first_out), .ptr_second_out(ptr_second_out),
    .nvm_ctrl_out(nvm_ctrl_out), .disp_wr_valid(disp_wr_valid),
    .disp_wr_addr(disp_wr_addr), .disp_wr_data(disp_wr_data));

// ===== tb/bdmi_core_host.sv
// Purpose: operand fetch and writeback side driving the memory port
// Assumes: one strobe per cycle, read data the cycle after the strobe
// Notes:   released lines show the inverse so stale values never match
`timescale 1ns/1ns
module bdmi_core_host (
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr_strobe,
    output logic            rd_strobe
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        addr <= ~a;
        @(negedge clock);
        v = rdata;
    endtask
endmodule

// ===== tb/bdmi_core_tb.sv
// Purpose: directed test of banked memory, pointers and display strobe
// Assumes: 100 ns clock, reset held six cycles
// Notes:   expectations follow the address map, not the design outputs
`timescale 1ns/1ns
module bdmi_core_tb;
    reg          clock = 1'b0;
    reg          rst_n = 1'b0;
    reg          sys_reset = 1'b0;
    reg          reset_keep_bank = 1'b0;
    wire [7:0]   addr, wdata, rdata, ptr_first_out, ptr_second_out, nvm_ctrl_out, disp_wr_data;
    wire         wr_strobe, rd_strobe, disp_wr_valid;
    wire [1:0]   bank_select_out;
    wire [6:0]   disp_wr_addr;
    integer      err_total = 0;
    integer      compares = 0;
    integer      i;
    logic [7:0]  d;
    always #50 clock = ~clock;
    bdmi_core_host i_host (.clock(clock), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe));
    bdmi_core i_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .sys_reset(sys_reset),
        .reset_keep_bank(reset_keep_bank), .bank_select_out(bank_select_out),
        .ptr_first_out(ptr_first_out), .ptr_second_out(ptr_second_out),
        .nvm_ctrl_out(nvm_ctrl_out), .disp_wr_valid(disp_wr_valid),
        .disp_wr_addr(disp_wr_addr), .disp_wr_data(disp_wr_data));
    task final_report;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        chk("rdata", d, e);
    endtask
    task sysr(input logic k);
        @(posedge clock);
        sys_reset <= 1'b1;
        reset_keep_bank <= k;
        @(posedge clock);
        sys_reset <= 1'b0;
        reset_keep_bank <= 1'b0;
        @(negedge clock);
    endtask
    // hang guard, far beyond the fewer than a hundred cycles of the sequence
    initial begin
        #1000000;
        err_total = err_total + 1;
        final_report;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rchk(8'h04, 8'h00);
        i_host.wr(8'h01, 8'h90);
        i_host.wr(8'h00, 8'hA5);
        rchk(8'h90, 8'hA5);
        i_host.wr(8'h04, 8'h02);
        i_host.wr(8'h91, 8'h5A);
        i_host.wr(8'h03, 8'h91);
        i_host.wr(8'h02, 8'hC3);
        rchk(8'h91, 8'h5A);
        rchk(8'h02, 8'hC3);
        rchk(8'h03, 8'h91);
        // upper bits written as ones must read back as zero
        for (i = 0; i < 4; i = i + 1) begin
            i_host.wr(8'h04, 8'hFC | i[7:0]);
            rchk(8'h04, i[7:0]);
        end
        rchk(8'h02, 8'h00);
        i_host.wr(8'h02, 8'h77);
        i_host.wr(8'h04, 8'h02);
        rchk(8'h02, 8'hC3);
        i_host.wr(8'h01, 8'h02);
        rchk(8'h00, 8'h00);
        i_host.wr(8'h00, 8'h11);
        rchk(8'h01, 8'h02);
        rchk(8'h13, 8'h00);
        i_host.wr(8'h04, 8'h01);
        i_host.wr(8'h03, 8'h85);
        i_host.wr(8'h02, 8'h3C);
        @(negedge clock);
        chk("disp_valid", {7'h00, disp_wr_valid}, 8'h01);
        chk("disp_addr", {1'b0, disp_wr_addr}, 8'h05);
        chk("disp_data", disp_wr_data, 8'h3C);
        @(negedge clock);
        chk("disp_pulse_end", {7'h00, disp_wr_valid}, 8'h00);
        rchk(8'h02, 8'h3C);
        i_host.wr(8'h03, 8'h40);
        i_host.wr(8'h02, 8'h5C);
        @(negedge clock);
        chk("nvm_ctrl", nvm_ctrl_out, 8'h5C);
        rchk(8'h40, 8'h00);
        sysr(1'b1);
        chk("bank_kept", {6'h00, bank_select_out}, 8'h01);
        sysr(1'b0);
        chk("bank_clr", {6'h00, bank_select_out}, 8'h00);
        chk("ptr_clr", ptr_first_out, 8'h00);
        chk("ptr2_clr", ptr_second_out, 8'h00);
        final_report;
    end
endmodule
